//--- addr_match.sv
// Purpose: compare a received address byte with the own address under mask
// Assumes: byte holds the address bits in bus order, r/w in bit 0
// Notes: purely combinational
`timescale 1ns/1ps
module addr_match (
  input wire logic [7:0] rx_byte,
  input wire logic [i2c_stat_pkg::MASK_W-1:0] own,
  input wire logic [i2c_stat_pkg::MASK_W-1:0] mask,
  output logic hit7,
  output logic hit10_hi,
  output logic hit10_lo
);
  import i2c_stat_pkg::*;

  // a set mask bit means the position need not match
  function automatic logic masked_eq(logic [MASK_W-1:0] a, logic [MASK_W-1:0] b,
                                     logic [MASK_W-1:0] m);
    masked_eq = ((a ^ b) & ~m) == '0;
  endfunction

  assign hit7 = masked_eq({3'h0, rx_byte[7:1]}, {3'h0, own[6:0]}, {3'h0, mask[6:0]});
  assign hit10_hi = (rx_byte[7:3] == TEN_PREFIX) &&
                    masked_eq({8'h00, rx_byte[2:1]}, {8'h00, own[9:8]}, {8'h00, mask[9:8]});
  assign hit10_lo = masked_eq({2'h0, rx_byte}, {2'h0, own[7:0]}, {2'h0, mask[7:0]});
endmodule

//--- bus_cond_if.sv
// Purpose: carries synchronised line events from the detector to the slave
// Assumes: all signals on pclk
// Notes: events are one-cycle pulses, sda is a level
`timescale 1ns/1ps
interface bus_cond_if;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  modport src (output start, output stop, output scl_rise, output scl_fall, output sda);
  modport dst (input start, input stop, input scl_rise, input scl_fall, input sda);
endinterface

//--- i2c_master_model.sv
// Purpose: two-wire bus master model, drives scl and pulls sda low
// Assumes: sda has a pull-up; scl idles high between frames
// Notes: one bit takes 25 pclk, 125 ns; slave never stretches scl
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic pclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // serves as start and repeated start: release sda while scl low
  task automatic bus_start();
    sda_pull <= 1'b0;
    wait_clk(6);
    scl <= 1'b1;
    wait_clk(12);
    sda_pull <= 1'b1;
    wait_clk(12);
    scl <= 1'b0;
    wait_clk(7);
  endtask

  task automatic bus_stop();
    sda_pull <= 1'b1;
    wait_clk(6);
    scl <= 1'b1;
    wait_clk(12);
    sda_pull <= 1'b0;
    wait_clk(12);
  endtask

  // eight data bits msb first, then the ninth bit; d=FF releases for reads
  task automatic bus_byte(input logic [7:0] d, input logic ack_out,
                          output logic [7:0] r, output logic acked);
    logic [8:0] v;
    logic [8:0] got;
    v = {d, ack_out};
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull <= ~v[i];
      wait_clk(6);
      scl <= 1'b1;
      wait_clk(12);
      got[i] = sda_line;
      scl <= 1'b0;
      wait_clk(7);
    end
    r = got[8:1];
    acked = ~got[0];
  endtask
endmodule

//--- i2c_stat_pkg.sv
// Purpose: shared constants and types of the two-wire slave status block
// Assumes: 32-bit APB data, byte addresses, 200 MHz pclk
// Notes: one word per register; unused upper bits read as zero
package i2c_stat_pkg;
  localparam int APB_AW = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_RXD = 8'h0C;
  localparam logic [7:0] OFS_TXD = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam int STAT_START = 3;
  localparam int STAT_RW = 2;
  localparam int STAT_RXF = 1;
  localparam int STAT_TXF = 0;
  localparam int MASK_W = 10;
  localparam int CTRL_EN = 0;
  localparam int CTRL_TEN = 1;
  localparam int CTRL_OWN_LSB = 16;
  localparam int IRQ_W = 5;
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_MATCH = 2;
  localparam int IRQ_RX = 3;
  localparam int IRQ_TX = 4;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int PCLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 125;
  localparam int SCL_CYCLES = SCL_PERIOD_NS / PCLK_PERIOD_NS;
  localparam int MIN_SCL_CYCLES = 8;
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR2,
    S_AACK,
    S_RX,
    S_RACK,
    S_TX,
    S_TACK,
    S_IGNORE
  } slave_state_e;
endpackage

//--- i2c_status_and_address_mask_tb.sv
// Purpose: self-checking bench for the status flags and address mask
// Assumes: zero-wait APB slave; bus master model on the far side
// Notes: sda is wired-and with a pull-up
`timescale 1ns/1ps
module i2c_status_and_address_mask_tb;
  import i2c_stat_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, sda_o, sda_oe, irq, scl, sda_pull, sda_line;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] d;
  logic [7:0] rb;
  logic ak, er;

  always #2.5 pclk = ~pclk;
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));

  i2c_status_mask dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .irq(irq));

  i2c_master_model partner_u (.pclk(pclk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // irq settles only after the access edge, so look one edge later
  task automatic chk_irq(input logic exp);
    @(posedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h0);
    rd_chk(OFS_MASK, 32'hFFFFFFFF, 32'h0);
    wr(OFS_MASK, 32'hFFFFFFFF);
    rd_chk(OFS_MASK, 32'hFFFFFFFF, 32'h3FF);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h0052_0001);
    wr(OFS_IMASK, 32'h1F);
    // one bit off with no masking must not be acknowledged
    partner_u.bus_start();
    rd_chk(OFS_STATUS, 32'hF, 32'h8);
    partner_u.bus_byte(8'hA6, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h0);
    partner_u.bus_stop();
    rd_chk(OFS_STATUS, 32'h8, 32'h0);
    // same address with bit 0 masked is accepted, then a byte is written in
    wr(OFS_MASK, 32'h1);
    partner_u.bus_start();
    partner_u.bus_byte(8'hA6, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h1);
    partner_u.bus_byte(8'hA5, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h1);
    rd_chk(OFS_STATUS, 32'hF, 32'hA);
    rd_chk(OFS_RXD, 32'hFF, 32'hA5);
    rd_chk(OFS_STATUS, 32'hF, 32'h8);
    chk_irq(1'b1);
    wr(OFS_ISTAT, 32'h1F);
    chk_irq(1'b0);
    partner_u.bus_stop();
    chk_irq(1'b1);
    wr(OFS_IMASK, 32'h0);
    chk_irq(1'b0);
    wr(OFS_IMASK, 32'h1F);
    wr(OFS_ISTAT, 32'h1F);
    // slave read: exact address, transmit byte goes out msb first
    wr(OFS_MASK, 32'h0);
    wr(OFS_TXD, 32'h3C);
    rd_chk(OFS_STATUS, 32'hF, 32'h1);
    partner_u.bus_start();
    partner_u.bus_byte(8'hA5, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h1);
    rd_chk(OFS_STATUS, 32'hF, 32'hD);
    partner_u.bus_byte(8'hFF, 1'b1, rb, ak);
    chk({24'h0, rb}, 32'h3C);
    rd_chk(OFS_STATUS, 32'h1, 32'h0);
    partner_u.bus_stop();
    // unmapped address is refused and reads zero
    apb(1'b0, 8'h40, 32'h0, d, er);
    chk({31'h0, er}, 32'h1);
    chk(d, 32'h0);
    // ten-bit address, both bytes acknowledged
    wr(OFS_CTRL, 32'h02A5_0003);
    partner_u.bus_start();
    partner_u.bus_byte(8'hF4, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h1);
    partner_u.bus_byte(8'hA5, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h1);
    // restart and read reuses the full ten-bit match
    partner_u.bus_start();
    partner_u.bus_byte(8'hF5, 1'b1, rb, ak);
    chk({31'h0, ak}, 32'h1);
    rd_chk(OFS_STATUS, 32'h4, 32'h4);
    partner_u.bus_stop();
    // disabling clears the start flag
    partner_u.bus_start();
    rd_chk(OFS_STATUS, 32'h8, 32'h8);
    wr(OFS_CTRL, 32'h0);
    rd_chk(OFS_STATUS, 32'h8, 32'h0);
    partner_u.bus_stop();
    complete_run();
  end
endmodule

//--- i2c_status_mask.sv
// Purpose: two-wire slave with status flags and masked address match, on APB
// Assumes: scl and sda are asynchronous pins, slave never stretches scl
// Notes: zero-wait APB, read data captured in the setup cycle
// Notes on behaviour
// - start flag updates on start, restart or stop; cleared while disabled.
// - start flag reads one after start or restart until a stop; zero after stop.
// - direction flag is one for slave read, zero for slave write.
// - receive-full set when a byte lands in the receive register.
// - transmit-full stays set until the eight bits have gone out.
// - mask register holds ten writable bits; bits above read zero.
// - a mask bit of one ignores that address position.
// - a mask bit of zero requires that address bit to match.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module i2c_status_mask #(
  parameter logic [9:0] OWN_ADDR_RST = 10'h000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_stat_pkg::APB_AW-1:0] paddr,
  input wire logic [i2c_stat_pkg::DATA_W-1:0] pwdata,
  output logic [i2c_stat_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  import i2c_stat_pkg::*;

  if (SCL_CYCLES < MIN_SCL_CYCLES)
  begin : g_rate_check
    $error("scl too fast for edge sampling");
  end

  typedef struct packed {
    slave_state_e state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic drive;
    logic ovf;
    logic addr2_pending;
    logic matched10;
    logic rw;
    logic start_flag;
    logic [7:0] rx_data;
    logic rx_full;
    logic [7:0] tx_data;
    logic tx_full;
    logic enable;
    logic ten_bit;
    logic [MASK_W-1:0] own;
    logic [MASK_W-1:0] mask;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic [DATA_W-1:0] rdata;
  } regs_s;

  localparam regs_s REGS_RST = '{state: S_IDLE, own: OWN_ADDR_RST, default: '0};

  regs_s st;
  regs_s next_st;
  logic [IRQ_W-1:0] ev;
  logic setup_ph;
  logic acc_wr;
  logic acc_rd;
  logic rd_rx;
  logic wr_tx;
  logic hit7;
  logic hit10_hi;
  logic hit10_lo;

  bus_cond_if cond ();

  line_cond_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .cond(cond)
  );

  addr_match u_match (
    .rx_byte(st.shreg),
    .own(st.own),
    .mask(st.mask),
    .hit7(hit7),
    .hit10_hi(hit10_hi),
    .hit10_lo(hit10_lo)
  );

  function automatic logic mapped(logic [APB_AW-1:0] a);
    mapped = a inside {OFS_STATUS, OFS_MASK, OFS_CTRL, OFS_RXD, OFS_TXD, OFS_ISTAT, OFS_IMASK};
  endfunction

  function automatic logic [DATA_W-1:0] read_word(regs_s s, logic [APB_AW-1:0] a);
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      OFS_STATUS:
      begin
        r[STAT_START] = s.start_flag;
        r[STAT_RW] = s.rw;
        r[STAT_RXF] = s.rx_full;
        r[STAT_TXF] = s.tx_full;
      end
      OFS_MASK: r[MASK_W-1:0] = s.mask;
      OFS_CTRL:
      begin
        r[CTRL_EN] = s.enable;
        r[CTRL_TEN] = s.ten_bit;
        r[CTRL_OWN_LSB +: MASK_W] = s.own;
      end
      OFS_RXD: r[7:0] = s.rx_data;
      OFS_TXD: r[7:0] = s.tx_data;
      OFS_ISTAT: r[IRQ_W-1:0] = s.istat;
      OFS_IMASK: r[IRQ_W-1:0] = s.imask;
      default: r = '0;
    endcase
    read_word = r;
  endfunction

  assign setup_ph = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign rd_rx = acc_rd && (paddr == OFS_RXD);
  assign wr_tx = acc_wr && (paddr == OFS_TXD);

  always_comb
  begin
    next_st = st;
    ev = '0;
    if (setup_ph)
      next_st.rdata = read_word(st, paddr);
    if (acc_wr)
    begin
      case (paddr)
        OFS_MASK: next_st.mask = pwdata[MASK_W-1:0];
        OFS_CTRL:
        begin
          next_st.enable = pwdata[CTRL_EN];
          next_st.ten_bit = pwdata[CTRL_TEN];
          next_st.own = pwdata[CTRL_OWN_LSB +: MASK_W];
        end
        OFS_TXD: next_st.tx_data = pwdata[7:0];
        OFS_ISTAT: next_st.istat = st.istat & ~pwdata[IRQ_W-1:0];
        OFS_IMASK: next_st.imask = pwdata[IRQ_W-1:0];
        default: next_st.imask = st.imask;
      endcase
    end
    // software clear first so a byte landing now still sets the flag
    if (rd_rx)
      next_st.rx_full = 1'b0;
    if (!st.enable)
    begin
      next_st.state = S_IDLE;
      next_st.drive = 1'b0;
      next_st.start_flag = 1'b0;
      next_st.matched10 = 1'b0;
    end
    else if (cond.start)
    begin
      next_st.state = S_ADDR;
      next_st.cnt = '0;
      next_st.drive = 1'b0;
      next_st.start_flag = 1'b1;
      ev[IRQ_START] = 1'b1;
    end
    else if (cond.stop)
    begin
      next_st.state = S_IDLE;
      next_st.drive = 1'b0;
      next_st.start_flag = 1'b0;
      next_st.matched10 = 1'b0;
      ev[IRQ_STOP] = 1'b1;
    end
    else
    begin
      unique case (st.state)
        S_IDLE, S_IGNORE: next_st.drive = 1'b0;
        S_ADDR, S_ADDR2:
        begin
          if (cond.scl_rise && st.cnt < BYTE_BITS)
          begin
            next_st.shreg = {st.shreg[6:0], cond.sda};
            next_st.cnt = st.cnt + 4'h1;
          end
          else if (cond.scl_fall && st.cnt == BYTE_BITS)
          begin
            next_st.cnt = '0;
            next_st.state = S_IGNORE;
            if (st.state == S_ADDR2)
            begin
              next_st.matched10 = hit10_lo;
              if (hit10_lo)
              begin
                next_st.state = S_AACK;
                next_st.drive = 1'b1;
                next_st.rw = 1'b0;
                ev[IRQ_MATCH] = 1'b1;
              end
            end
            else if (!st.ten_bit)
            begin
              if (hit7)
              begin
                next_st.state = S_AACK;
                next_st.drive = 1'b1;
                next_st.rw = st.shreg[0];
                ev[IRQ_MATCH] = 1'b1;
              end
            end
            else if (hit10_hi && !st.shreg[0])
            begin
              next_st.state = S_AACK;
              next_st.drive = 1'b1;
              next_st.addr2_pending = 1'b1;
            end
            else if (hit10_hi && st.matched10)
            begin
              // read after restart reuses the earlier full match
              next_st.state = S_AACK;
              next_st.drive = 1'b1;
              next_st.rw = 1'b1;
              ev[IRQ_MATCH] = 1'b1;
            end
          end
        end
        S_AACK:
        begin
          if (cond.scl_fall)
          begin
            next_st.cnt = '0;
            next_st.drive = 1'b0;
            if (st.addr2_pending)
            begin
              next_st.addr2_pending = 1'b0;
              next_st.state = S_ADDR2;
            end
            else if (st.rw)
            begin
              next_st.state = S_TX;
              next_st.shreg = st.tx_data;
              next_st.drive = ~st.tx_data[7];
            end
            else
              next_st.state = S_RX;
          end
        end
        S_RX:
        begin
          if (cond.scl_rise && st.cnt < BYTE_BITS)
          begin
            next_st.shreg = {st.shreg[6:0], cond.sda};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == LAST_BIT)
            begin
              // an unread byte is kept; the new one is refused
              next_st.ovf = st.rx_full;
              if (!st.rx_full)
                next_st.rx_data = {st.shreg[6:0], cond.sda};
              next_st.rx_full = 1'b1;
              ev[IRQ_RX] = 1'b1;
            end
          end
          else if (cond.scl_fall && st.cnt == BYTE_BITS)
          begin
            next_st.drive = ~st.ovf;
            next_st.state = S_RACK;
          end
        end
        S_RACK:
        begin
          if (cond.scl_fall)
          begin
            next_st.drive = 1'b0;
            next_st.cnt = '0;
            next_st.state = S_RX;
          end
        end
        S_TX:
        begin
          if (cond.scl_rise && st.cnt < BYTE_BITS)
          begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == LAST_BIT)
            begin
              next_st.tx_full = 1'b0;
              ev[IRQ_TX] = 1'b1;
            end
          end
          else if (cond.scl_fall && st.cnt == BYTE_BITS)
          begin
            next_st.drive = 1'b0;
            next_st.state = S_TACK;
          end
          else if (cond.scl_fall && st.cnt != 4'h0)
          begin
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.drive = ~st.shreg[6];
          end
        end
        S_TACK:
        begin
          if (cond.scl_rise)
            next_st.ovf = cond.sda;
          else if (cond.scl_fall)
          begin
            next_st.cnt = '0;
            if (st.ovf)
              next_st.state = S_IGNORE;
            else
            begin
              next_st.state = S_TX;
              next_st.shreg = st.tx_data;
              next_st.drive = ~st.tx_data[7];
            end
          end
        end
        default: next_st.state = S_IDLE;
      endcase
    end
    // software set after hardware clear so a write in the same cycle wins
    if (wr_tx)
      next_st.tx_full = 1'b1;
    next_st.istat = next_st.istat | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= REGS_RST;
    else
      st <= next_st;
  end

  assign prdata = st.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped(paddr);
  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = st.drive;
  assign irq = |(st.istat & st.imask);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence rx_byte_s;
    st.enable && !cond.start && !cond.stop && st.state == S_RX && cond.scl_rise &&
      st.cnt == LAST_BIT;
  endsequence

  sequence tx_byte_s;
    st.enable && !cond.start && !cond.stop && st.state == S_TX && cond.scl_rise &&
      st.cnt == LAST_BIT;
  endsequence

  sequence addr7_ack_s;
    $rose(st.state == S_AACK) && !st.ten_bit;
  endsequence

  start_set_a: assert property (
    st.enable && cond.start |=> st.start_flag && st.state == S_ADDR)
    else $error("start flag not set after start");

  stop_clear_a: assert property (
    st.enable && cond.stop |=> !st.start_flag ##1 (!st.start_flag || $past(cond.start)))
    else $error("start flag not cleared after stop");

  disable_clear_a: assert property (
    !st.enable |=> !st.start_flag)
    else $error("start flag set while disabled");

  mask_upper_a: assert property (
    setup_ph && paddr == OFS_MASK |=> prdata[DATA_W-1:MASK_W] == '0)
    else $error("mask upper bits not zero");

  mask_store_a: assert property (
    acc_wr && paddr == OFS_MASK |=> st.mask == $past(pwdata[MASK_W-1:0]))
    else $error("mask write not stored");

  rx_full_set_a: assert property (
    rx_byte_s |=> st.rx_full && st.state == S_RX)
    else $error("receive full not set");

  rx_read_clear_a: assert property (
    rd_rx && !ev[IRQ_RX] |=> !st.rx_full)
    else $error("receive full not cleared on read");

  tx_write_set_a: assert property (
    wr_tx |=> st.tx_full)
    else $error("transmit full not set on write");

  tx_done_a: assert property (
    tx_byte_s ##0 !wr_tx |=> !st.tx_full && st.istat[IRQ_TX])
    else $error("transmit full not cleared after byte");

  addr_match_a: assert property (
    addr7_ack_s |-> (((st.shreg[7:1] ^ st.own[6:0]) & ~st.mask[6:0]) == 7'h00) && sda_oe)
    else $error("address acknowledged without match");

  rw_capture_a: assert property (
    addr7_ack_s |-> st.rw == st.shreg[0])
    else $error("direction flag differs from address byte");
endmodule

//--- line_cond_detect.sv
// Purpose: synchronise scl and sda and find edges, start and stop
// Assumes: scl slower than a few pclk periods
// Notes: idle-high reset keeps a spurious start away after reset
`timescale 1ns/1ps
module line_cond_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_i,
  input wire logic sda_i,
  bus_cond_if.src cond
);
  import i2c_stat_pkg::*;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
  } sync_s;

  localparam sync_s SYNC_RST = '1;

  sync_s st;
  sync_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.scl_m = scl_i;
    next_st.scl_s = st.scl_m;
    next_st.scl_p = st.scl_s;
    next_st.sda_m = sda_i;
    next_st.sda_s = st.sda_m;
    next_st.sda_p = st.sda_s;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= SYNC_RST;
    else
      st <= next_st;
  end

  // only the second and third stages are looked at
  assign cond.start = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
  assign cond.stop = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
  assign cond.scl_rise = st.scl_s & ~st.scl_p;
  assign cond.scl_fall = ~st.scl_s & st.scl_p;
  assign cond.sda = st.sda_s;
endmodule
